// [rtl/csif_core.sv]
/*
  stack pointer bank, push/pop addressing, call/return, exception entry, low-power halt,
  table interpolation and instruction word framing.
  assumes a same-clock memory that holds MEM_REQ_O high until MEM_ACK_I; interrupt level comes from pins.
*/
`timescale 1ns/1ps
module csif_core
  import csif_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CMD_VALID_I,
  output logic             CMD_READY_O,
  input  wire logic [3:0]  CMD_OP_I,
  input  wire logic [2:0]  CMD_REG_I,
  input  wire logic [1:0]  CMD_SIZE_I,
  input  wire logic        CMD_ROUND_I,
  input  wire logic [31:0] CMD_DATA_I,
  output logic             CMD_DONE_O,
  output logic [31:0]      CMD_RESULT_O,
  output logic [7:0]       CMD_FRAC_O,
  output logic             MEM_REQ_O,
  output logic             MEM_WE_O,
  output logic [31:0]      MEM_ADDR_O,
  output logic [1:0]       MEM_SIZE_O,
  output logic [31:0]      MEM_WDATA_O,
  input  wire logic        MEM_ACK_I,
  input  wire logic [31:0] MEM_RDATA_I,
  input  wire logic [2:0]  IRQ_LEVEL_I,
  output logic             WORD_VALID_O,
  output logic [1:0]       WORD_KIND_O,
  output logic [15:0]      WORD_O,
  output logic [31:0]      PC_O,
  output logic [15:0]      STATUS_WORD_O,
  output logic             SUPERVISOR_O,
  output logic             HALTED_O,
  output logic             TRAP_O
);

  typedef struct packed {
    csif_state_t     st;
    logic [6:0][31:0] gp;
    logic [31:0]     supervisor_stack_pointer;
    logic [31:0]     user_stack_pointer;
    logic [31:0]     pc;
    logic [15:0]     sw;
    logic [3:0]      op;
    logic [2:0]      rn;
    logic [1:0]      sz;
    logic            rnd;
    logic [31:0]     arg;
    logic            step;
    logic            by_cmd;
    logic [31:0]     exc_target;
    logic [15:0]     exc_sw;
    logic [1:0]      n_spec;
    logic [1:0]      n_src;
    logic [1:0]      n_dst;
    logic [2:0]      widx;
    logic [31:0]     e0;
    logic            mem_req;
    logic            mem_we;
    logic [31:0]     mem_addr;
    logic [1:0]      mem_sz;
    logic [31:0]     mem_wdata;
    logic            done;
    logic [31:0]     result;
    logic [7:0]      frac;
    logic            word_valid;
    logic [1:0]      word_kind;
    logic [15:0]     word;
    logic            trap;
    logic            halted;
    logic [2:0]      irq_s1;
    logic [2:0]      irq_s2;
    logic [2:0]      irq_s3;
    logic [2:0]      irq_lvl;
  } csif_core_t;

  csif_core_t  q;
  csif_core_t  d;
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic        take_irq;
  logic [31:0] tbl_value;
  logic [7:0]  tbl_frac;

  ////////////////////////////////////////////////////////////////////////////////
  // pointer bank access

  // number seven resolves to whichever stack the state bit selects; the other stays hidden
  function automatic logic [31:0] get_ptr(input csif_core_t s, input logic [2:0] rn);
    if (rn == SYS_PTR_IDX) begin
      return s.sw[SW_S_BIT] ? s.supervisor_stack_pointer : s.user_stack_pointer;
    end
    return s.gp[rn];
  endfunction

  function automatic csif_core_t set_ptr(input csif_core_t s, input logic [2:0] rn, input logic [31:0] v);
    csif_core_t r;
    r = s;
    if (rn != SYS_PTR_IDX) begin
      r.gp[rn] = v;
    end else if (s.sw[SW_S_BIT]) begin
      r.supervisor_stack_pointer = v;
    end else begin
      r.user_stack_pointer = v;
    end
    return r;
  endfunction

  // exception entry: always onto the supervisor stack, counter first, status word below it
  function automatic csif_core_t start_exc(input csif_core_t s, input logic [31:0] tgt, input logic cmd);
    csif_core_t r;
    r              = s;
    r.exc_sw       = s.sw;
    r.sw[SW_S_BIT] = 1'b1;
    r.supervisor_stack_pointer          = s.supervisor_stack_pointer - 32'h0000_0004;
    r.mem_req      = 1'b1;
    r.mem_we       = 1'b1;
    r.mem_addr     = r.supervisor_stack_pointer;
    r.mem_sz       = SZ_LONG;
    r.mem_wdata    = s.pc;
    r.exc_target   = tgt;
    r.by_cmd       = cmd;
    r.step         = 1'b0;
    r.st           = ST_EXC;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and interpolator

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  csif_interp u_interp (
    .entry_lo_i (q.e0),
    .entry_hi_i (sext(MEM_RDATA_I, q.sz)),
    .frac_i     (q.arg[TBL_FRAC_W-1:0]),
    .size_i     (q.sz),
    .round_i    (q.rnd),
    .value_o    (tbl_value),
    .frac_o     (tbl_frac)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  assign take_irq = q.st == ST_IDLE && q.irq_lvl != 3'h0 &&
                    (q.irq_lvl > q.sw[SW_MASK_LSB +: 3] || q.irq_lvl == LVL_NMI);

  always_comb begin
    logic [31:0] a;
    logic [3:0]  len;
    a            = 32'h0000_0000;
    len          = frame_len(q.n_spec, q.n_src, q.n_dst);
    d            = q;
    d.done       = 1'b0;
    d.word_valid = 1'b0;
    d.trap       = 1'b0;
    d.irq_s1     = IRQ_LEVEL_I;
    d.irq_s2     = q.irq_s1;
    d.irq_s3     = q.irq_s2;
    if (q.irq_s2 == q.irq_s3) begin
      d.irq_lvl = q.irq_s3;
    end
    case (q.st)
      ST_IDLE: begin
        if (take_irq) begin
          d = start_exc(d, INT_TARGET_BASE + {27'h0, q.irq_lvl, 2'h0}, 1'b0);
          d.sw[SW_MASK_LSB +: 3] = q.irq_lvl;
        end else if (CMD_VALID_I) begin
          d.op  = CMD_OP_I;
          d.rn  = CMD_REG_I;
          d.sz  = CMD_SIZE_I;
          d.rnd = CMD_ROUND_I;
          d.arg = CMD_DATA_I;
          case (CMD_OP_I)
            CMD_RD_PTR: begin
              d.result = get_ptr(q, CMD_REG_I);
              d.done   = 1'b1;
            end
            CMD_WR_PTR: begin
              d      = set_ptr(d, CMD_REG_I, CMD_DATA_I);
              d.done = 1'b1;
            end
            CMD_PUSH: begin
              // pointer moves before the access; a system-stack byte lands in the upper half
              a           = get_ptr(q, CMD_REG_I) - ptr_step(CMD_SIZE_I, CMD_REG_I);
              d           = set_ptr(d, CMD_REG_I, a);
              d.mem_req   = 1'b1;
              d.mem_we    = 1'b1;
              d.mem_addr  = a;
              d.mem_sz    = CMD_SIZE_I;
              d.mem_wdata = fit(CMD_DATA_I, CMD_SIZE_I);
              d.st        = ST_ACCESS;
            end
            CMD_POP: begin
              a          = get_ptr(q, CMD_REG_I);
              d          = set_ptr(d, CMD_REG_I, a + ptr_step(CMD_SIZE_I, CMD_REG_I));
              d.mem_req  = 1'b1;
              d.mem_we   = 1'b0;
              d.mem_addr = a;
              d.mem_sz   = CMD_SIZE_I;
              d.st       = ST_ACCESS;
            end
            CMD_CALL: begin
              a           = get_ptr(q, SYS_PTR_IDX) - 32'h0000_0004;
              d           = set_ptr(d, SYS_PTR_IDX, a);
              d.mem_req   = 1'b1;
              d.mem_we    = 1'b1;
              d.mem_addr  = a;
              d.mem_sz    = SZ_LONG;
              d.mem_wdata = q.pc;
              d.st        = ST_ACCESS;
            end
            CMD_RETURN: begin
              a          = get_ptr(q, SYS_PTR_IDX);
              d          = set_ptr(d, SYS_PTR_IDX, a + 32'h0000_0004);
              d.mem_req  = 1'b1;
              d.mem_we   = 1'b0;
              d.mem_addr = a;
              d.mem_sz   = SZ_LONG;
              d.st       = ST_ACCESS;
            end
            CMD_TRAP: begin
              d = start_exc(d, CMD_DATA_I, 1'b1);
            end
            CMD_SET_STATUS: begin
              d.sw   = CMD_DATA_I[15:0];
              d.done = 1'b1;
            end
            CMD_HALT: begin
              d.sw     = CMD_DATA_I[15:0];
              d.halted = 1'b1;
              d.st     = ST_HALT;
            end
            CMD_FRAME: begin
              d.mem_req  = 1'b1;
              d.mem_we   = 1'b0;
              d.mem_addr = q.pc;
              d.mem_sz   = SZ_WORD;
              d.widx     = 3'h0;
              d.st       = ST_FRAME;
            end
            CMD_TABLE: begin
              a          = get_ptr(q, CMD_REG_I) +
                           32'(CMD_DATA_I[TBL_IDX_LSB +: 8] * size_bytes(CMD_SIZE_I));
              d.mem_req  = 1'b1;
              d.mem_we   = 1'b0;
              d.mem_addr = a;
              d.mem_sz   = CMD_SIZE_I;
              d.step     = 1'b0;
              d.st       = ST_TBL;
            end
            default: begin
              d = start_exc(d, UNIMP_TARGET, 1'b1);
            end
          endcase
        end
      end
      ST_ACCESS: begin
        if (MEM_ACK_I) begin
          d.mem_req = 1'b0;
          d.done    = 1'b1;
          d.st      = ST_IDLE;
          if (q.op == CMD_POP) begin
            d.result = fit(MEM_RDATA_I, q.sz);
          end else if (q.op == CMD_RETURN) begin
            d.pc = MEM_RDATA_I;
          end else if (q.op == CMD_CALL) begin
            d.pc = q.arg;
          end
        end
      end
      ST_EXC: begin
        if (MEM_ACK_I) begin
          if (!q.step) begin
            d.supervisor_stack_pointer       = q.supervisor_stack_pointer - 32'h0000_0002;
            d.mem_addr  = d.supervisor_stack_pointer;
            d.mem_sz    = SZ_WORD;
            d.mem_wdata = {16'h0000, q.exc_sw};
            d.step      = 1'b1;
          end else begin
            d.mem_req = 1'b0;
            d.pc      = q.exc_target;
            d.trap    = 1'b1;
            d.done    = q.by_cmd;
            d.st      = ST_IDLE;
          end
        end
      end
      ST_HALT: begin
        // leaves standby at a nonzero level at or above the loaded mask; only reset clears it otherwise
        if (q.irq_lvl != 3'h0 && q.irq_lvl >= q.sw[SW_MASK_LSB +: 3]) begin
          d.halted = 1'b0;
          d.done   = 1'b1;
          d.st     = ST_IDLE;
        end
      end
      ST_FRAME: begin
        if (MEM_ACK_I) begin
          d.pc       = q.pc + 32'h0000_0002;
          d.mem_addr = d.pc;
          d.word     = MEM_RDATA_I[15:0];
          d.widx     = q.widx + 3'h1;
          if (q.widx == 3'h0) begin
            d.n_spec = MEM_RDATA_I[FRM_SPEC_LSB +: 2];
            d.n_src  = MEM_RDATA_I[FRM_SRC_LSB +: 2];
            d.n_dst  = MEM_RDATA_I[FRM_DST_LSB +: 2];
            len      = frame_len(d.n_spec, d.n_src, d.n_dst);
            if (MEM_RDATA_I[FRM_CLASS_LSB +: 4] == FRM_UNIMP_CLASS || d.n_spec > FRM_MAX_SPEC ||
                len > FRM_MAX_WORDS) begin
              d = start_exc(d, UNIMP_TARGET, 1'b1);
            end else begin
              d.word_valid = 1'b1;
              d.word_kind  = KIND_OPWORD;
            end
          end else begin
            d.word_valid = 1'b1;
            if (q.widx <= {1'b0, q.n_spec}) begin
              d.word_kind = KIND_SPECIAL;
            end else if (q.widx <= {1'b0, q.n_spec} + {1'b0, q.n_src}) begin
              d.word_kind = KIND_SOURCE;
            end else begin
              d.word_kind = KIND_DEST;
            end
          end
          if (d.st == ST_FRAME && {1'b0, d.widx} == len) begin
            d.mem_req = 1'b0;
            d.result  = {28'h000_0000, len};
            d.done    = 1'b1;
            d.st      = ST_IDLE;
          end
        end
      end
      ST_TBL: begin
        if (MEM_ACK_I) begin
          if (!q.step) begin
            d.e0       = sext(MEM_RDATA_I, q.sz);
            d.mem_addr = q.mem_addr + size_bytes(q.sz);
            d.step     = 1'b1;
          end else begin
            d.mem_req = 1'b0;
            d.result  = tbl_value;
            d.frac    = tbl_frac;
            d.done    = 1'b1;
            d.st      = ST_IDLE;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      q     <= '0;
      q.st  <= ST_IDLE;
      q.sw  <= SW_RST;
      q.pc  <= PC_RST;
      q.supervisor_stack_pointer <= SSP_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign CMD_READY_O   = q.st == ST_IDLE && !take_irq;
  assign CMD_DONE_O    = q.done;
  assign CMD_RESULT_O  = q.result;
  assign CMD_FRAC_O    = q.frac;
  assign MEM_REQ_O     = q.mem_req;
  assign MEM_WE_O      = q.mem_we;
  assign MEM_ADDR_O    = q.mem_addr;
  assign MEM_SIZE_O    = q.mem_sz;
  assign MEM_WDATA_O   = q.mem_wdata;
  assign WORD_VALID_O  = q.word_valid;
  assign WORD_KIND_O   = q.word_kind;
  assign WORD_O        = q.word;
  assign PC_O          = q.pc;
  assign STATUS_WORD_O = q.sw;
  assign SUPERVISOR_O  = q.sw[SW_S_BIT];
  assign HALTED_O      = q.halted;
  assign TRAP_O        = q.trap;

endmodule

// [rtl/csif_pkg.sv]
/*
  constants, encodings and small helpers shared by the stack, framing and interpolation logic.
  assumes a big-endian memory with right-aligned read and write data and 16-bit instruction words.
*/
package csif_pkg;

  typedef enum logic [3:0] {
    CMD_RD_PTR     = 4'h0,
    CMD_WR_PTR     = 4'h1,
    CMD_PUSH       = 4'h2,
    CMD_POP        = 4'h3,
    CMD_CALL       = 4'h4,
    CMD_RETURN     = 4'h5,
    CMD_TRAP       = 4'h6,
    CMD_SET_STATUS = 4'h7,
    CMD_HALT       = 4'h8,
    CMD_FRAME      = 4'h9,
    CMD_TABLE      = 4'hA
  } csif_cmd_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_ACCESS = 6'h02,
    ST_EXC    = 6'h04,
    ST_HALT   = 6'h08,
    ST_FRAME  = 6'h10,
    ST_TBL    = 6'h20
  } csif_state_t;

  typedef enum logic [1:0] {
    KIND_OPWORD  = 2'h0,
    KIND_SPECIAL = 2'h1,
    KIND_SOURCE  = 2'h2,
    KIND_DEST    = 2'h3
  } csif_kind_t;

  localparam logic [1:0]  SZ_BYTE         = 2'h0;
  localparam logic [1:0]  SZ_WORD         = 2'h1;
  localparam logic [1:0]  SZ_LONG         = 2'h2;
  localparam logic [2:0]  SYS_PTR_IDX     = 3'h7;
  localparam int          SW_S_BIT        = 13;
  localparam int          SW_MASK_LSB     = 8;
  localparam logic [2:0]  LVL_NMI         = 3'h7;
  localparam logic [15:0] SW_RST          = 16'h2700;
  localparam logic [31:0] PC_RST          = 32'h0000_0000;
  localparam logic [31:0] SSP_RST         = 32'h0000_0000;
  localparam logic [31:0] UNIMP_TARGET    = 32'h0000_0400;
  localparam logic [31:0] INT_TARGET_BASE = 32'h0000_0500;
  localparam int          FRM_SPEC_LSB    = 0;
  localparam int          FRM_SRC_LSB     = 2;
  localparam int          FRM_DST_LSB     = 4;
  localparam int          FRM_CLASS_LSB   = 12;
  localparam logic [3:0]  FRM_UNIMP_CLASS = 4'hF;
  localparam logic [1:0]  FRM_MAX_SPEC    = 2'h2;
  localparam logic [3:0]  FRM_MAX_WORDS   = 4'h7;
  localparam int          TBL_IDX_LSB     = 8;
  localparam int          TBL_FRAC_W      = 8;

  function automatic logic [31:0] size_bytes(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: return 32'h0000_0001;
      SZ_WORD: return 32'h0000_0002;
      default: return 32'h0000_0004;
    endcase
  endfunction

  // a byte on the system stack still moves the pointer by a word so it stays aligned
  function automatic logic [31:0] ptr_step(input logic [1:0] sz, input logic [2:0] rn);
    if (sz == SZ_BYTE && rn == SYS_PTR_IDX) begin
      return 32'h0000_0002;
    end
    return size_bytes(sz);
  endfunction

  function automatic logic [31:0] sext(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      SZ_BYTE: return {{24{v[7]}}, v[7:0]};
      SZ_WORD: return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction

  function automatic logic [31:0] fit(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      SZ_BYTE: return {24'h00_0000, v[7:0]};
      SZ_WORD: return {16'h0000, v[15:0]};
      default: return v;
    endcase
  endfunction

  function automatic logic [3:0] frame_len(input logic [1:0] sp, input logic [1:0] sr, input logic [1:0] ds);
    return 4'h1 + {2'h0, sp} + {2'h0, sr} + {2'h0, ds};
  endfunction

endpackage

// [rtl/csif_interp.sv]
/*
  linear interpolation between two table entries with optional rounding.
  assumes both entries arrive already sign-extended to 32 bits for the operand size.
*/
`timescale 1ns/1ps
module csif_interp
  import csif_pkg::*;
(
  input  wire logic [31:0]           entry_lo_i,
  input  wire logic [31:0]           entry_hi_i,
  input  wire logic [TBL_FRAC_W-1:0] frac_i,
  input  wire logic [1:0]            size_i,
  input  wire logic                  round_i,
  output logic      [31:0]           value_o,
  output logic      [TBL_FRAC_W-1:0] frac_o
);

  logic signed [32:0] diff;
  logic signed [41:0] prod;
  logic signed [41:0] acc;
  logic signed [41:0] rnd;
  logic               use_round;

  always_comb begin
    diff      = $signed({entry_hi_i[31], entry_hi_i}) - $signed({entry_lo_i[31], entry_lo_i});
    // widen both factors first so a long difference times the fraction cannot wrap
    prod      = 42'(diff) * 42'($signed({1'b0, frac_i}));
    acc       = $signed({{2{entry_lo_i[31]}}, entry_lo_i, 8'h00}) + prod;
    rnd       = acc + 42'sh80;
    // long results have no room for the fraction, so they are always rounded
    use_round = round_i || size_i == SZ_LONG;
    value_o   = fit(use_round ? rnd[39:8] : acc[39:8], size_i);
    frac_o    = use_round ? 8'h00 : acc[7:0];
  end

endmodule

// [dv/csif_core_checker.sv]
/*
  port-level checks of csif_core: bus holding, stack accesses, exceptions, halt and word framing.
  assumes one clock and the active-low port reset; bound into csif_core below.
*/
`timescale 1ns/1ps
module csif_core_checker
  import csif_pkg::*;
(
  input logic        CLK_I,
  input logic        RST_N_I,
  input logic        CMD_VALID_I,
  input logic        CMD_READY_O,
  input logic [3:0]  CMD_OP_I,
  input logic [1:0]  CMD_SIZE_I,
  input logic        MEM_REQ_O,
  input logic        MEM_WE_O,
  input logic [31:0] MEM_ADDR_O,
  input logic [1:0]  MEM_SIZE_O,
  input logic [31:0] MEM_WDATA_O,
  input logic        MEM_ACK_I,
  input logic [2:0]  IRQ_LEVEL_I,
  input logic        WORD_VALID_O,
  input logic [31:0] PC_O,
  input logic        SUPERVISOR_O,
  input logic        HALTED_O,
  input logic        TRAP_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic take;
  assign take = CMD_VALID_I && CMD_READY_O;
  ////////////////////////////////////////////////////////////
  AST_REQ_HOLD: assert property (MEM_REQ_O && !MEM_ACK_I |=>
    MEM_REQ_O && $stable(MEM_ADDR_O) && $stable(MEM_WDATA_O)) else $error("request moved before ack");
  AST_BUSY: assert property (MEM_REQ_O |-> !CMD_READY_O) else $error("ready during access");
  AST_PUSH: assert property (take && CMD_OP_I == CMD_PUSH |=>
    MEM_REQ_O && MEM_WE_O && MEM_SIZE_O == $past(CMD_SIZE_I)) else $error("push access wrong");
  AST_POP: assert property (take && CMD_OP_I == CMD_POP |=> MEM_REQ_O && !MEM_WE_O)
    else $error("pop access wrong");
  AST_TRAP_ENTRY: assert property (take && CMD_OP_I == CMD_TRAP |=>
    MEM_WE_O && MEM_SIZE_O == SZ_LONG && SUPERVISOR_O) else $error("trap entry wrong");
  AST_TRAP_SUP: assert property (TRAP_O |-> SUPERVISOR_O) else $error("trap outside supervisor");
  AST_UNIMP: assert property (take && CMD_OP_I > 4'hA |-> ##[1:40] TRAP_O && PC_O == UNIMP_TARGET)
    else $error("unknown op did not trap");
  AST_HALT_STAY: assert property ((IRQ_LEVEL_I == 3'h0)[*6] ##0 HALTED_O |=> HALTED_O)
    else $error("halt left without cause");
  AST_WORD_ACK: assert property (WORD_VALID_O |-> $past(MEM_ACK_I) && !$past(MEM_WE_O))
    else $error("word without read ack");
endmodule
bind csif_core csif_core_checker i_chk (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O),
  .CMD_OP_I(CMD_OP_I), .CMD_SIZE_I(CMD_SIZE_I), .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O),
  .MEM_ADDR_O(MEM_ADDR_O), .MEM_SIZE_O(MEM_SIZE_O), .MEM_WDATA_O(MEM_WDATA_O), .MEM_ACK_I(MEM_ACK_I),
  .IRQ_LEVEL_I(IRQ_LEVEL_I), .WORD_VALID_O(WORD_VALID_O), .PC_O(PC_O), .SUPERVISOR_O(SUPERVISOR_O),
  .HALTED_O(HALTED_O), .TRAP_O(TRAP_O)
);

// [dv/csif_mem.sv]
/*
  memory partner: big-endian bytes, right-aligned data, ack one cycle after the request, or four cycles when slow_i is set.
  assumes requests hold until ack; only address bits 11:0 are decoded.
*/
`timescale 1ns/1ps
module csif_mem (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [7:0]  m [4096];
  logic [31:0] v;
  int          n_q;
  int          nb;
  initial begin
    foreach (m[i]) m[i] = 8'hEE;
    ack_o = 1'b0;
    rdata_o = 32'h0;
    n_q = 0;
  end
  ////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    // read data is only valid with ack, so it toggles otherwise
    rdata_o <= ~rdata_o;
    n_q <= (req_i && !ack_o) ? n_q + 1 : 0;
    if (req_i && !ack_o && n_q >= (slow_i ? 3 : 0)) begin
      nb = 1 << size_i;
      v = 32'h0;
      for (int i = 0; i < nb; i++) begin
        if (we_i) m[addr_i[11:0] + 12'(i)] = wdata_i[8 * (nb - 1 - i) +: 8];
        v = {v[23:0], m[addr_i[11:0] + 12'(i)]};
      end
      ack_o <= 1'b1;
      n_q <= 0;
      if (!we_i) rdata_o <= v;
    end
  end
endmodule

// [dv/csif_core_test.sv]
/*
  self-checking bench for csif_core with a memory model.
  assumes the checker is bound in and the memory answers every request.
*/
`timescale 1ns/1ps
module csif_core_test
  import csif_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        vld = 1'b0;
  logic [3:0]  op = 4'h0;
  logic [2:0]  rg = 3'h0;
  logic [1:0]  sz = 2'h0;
  logic        rnd = 1'b0;
  logic [31:0] dat = 32'h0;
  logic [2:0]  irq = 3'h0;
  logic        slow = 1'b0;
  logic        rdy, done, req, we, ack, wv, sup, hlt, trp;
  logic [1:0]  msz, wk;
  logic [7:0]  frac;
  logic [15:0] w, sw;
  logic [31:0] res, adr, wd, rdat, pc;
  logic [17:0] wq[$];
  int          err_count = 0;
  int          n_compared = 0;
  always #2 clk = ~clk;
  always @(negedge clk) if (wv) wq.push_back({wk, w});
  csif_core i_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(vld), .CMD_READY_O(rdy), .CMD_OP_I(op),
    .CMD_REG_I(rg), .CMD_SIZE_I(sz), .CMD_ROUND_I(rnd), .CMD_DATA_I(dat), .CMD_DONE_O(done),
    .CMD_RESULT_O(res), .CMD_FRAC_O(frac), .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_ADDR_O(adr),
    .MEM_SIZE_O(msz), .MEM_WDATA_O(wd), .MEM_ACK_I(ack), .MEM_RDATA_I(rdat), .IRQ_LEVEL_I(irq),
    .WORD_VALID_O(wv), .WORD_KIND_O(wk), .WORD_O(w), .PC_O(pc), .STATUS_WORD_O(sw),
    .SUPERVISOR_O(sup), .HALTED_O(hlt), .TRAP_O(trp)
  );
  csif_mem i_mem (
    .clk_i(clk), .slow_i(slow), .req_i(req), .we_i(we), .addr_i(adr), .size_i(msz),
    .wdata_i(wd), .ack_o(ack), .rdata_o(rdat)
  );
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] peek(input logic [11:0] a);
    return {i_mem.m[a], i_mem.m[a + 12'h1], i_mem.m[a + 12'h2], i_mem.m[a + 12'h3]};
  endfunction
  task automatic poke(input logic [11:0] a, input logic [31:0] v, input int nb);
    for (int i = 0; i < nb; i++) i_mem.m[a + 12'(i)] = v[8 * (nb - 1 - i) +: 8];
  endtask
  task automatic cmd(input logic [3:0] o, input logic [2:0] r = 3'h0, input logic [1:0] s = 2'h2,
                     input logic [31:0] d = 32'h0, input logic rn = 1'b1);
    int n;
    @(posedge clk);
    op <= o;
    rg <= r;
    sz <= s;
    dat <= d;
    rnd <= rn;
    vld <= 1'b1;
    n = 0;
    do @(negedge clk); while (rdy !== 1'b1 && ++n < 400);
    @(posedge clk);
    vld <= 1'b0;
    do @(negedge clk); while (done !== 1'b1 && ++n < 800);
    if (n >= 800) chk(32'h0, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_ptrs();
    logic [31:0] b, s, v;
    for (int r = 0; r < 7; r++) begin
      b = 32'h100 + 32'(r) * 32'h20;
      s = 32'h1 << (r % 3);
      v = 32'hC3D2E1F0 & ~(32'hFFFFFFFF << (s * 8));
      slow <= 1'(r);
      cmd(CMD_WR_PTR, 3'(r), SZ_LONG, b);
      cmd(CMD_PUSH, 3'(r), 2'(r % 3), 32'hC3D2E1F0);
      chk(32'(i_mem.m[12'(b - s)]), v >> (s * 8 - 8));
      cmd(CMD_RD_PTR, 3'(r));
      chk(res, b - s);
      cmd(CMD_POP, 3'(r), 2'(r % 3));
      chk(res, v);
      cmd(CMD_RD_PTR, 3'(r));
      chk(res, b);
    end
    $display("pointer test end");
  endtask
  task automatic t_sys();
    cmd(CMD_WR_PTR, 3'h7, SZ_LONG, 32'h800);
    cmd(CMD_SET_STATUS, 3'h0, SZ_WORD, 32'h0);
    chk(sup, 1'b0);
    cmd(CMD_WR_PTR, 3'h7, SZ_LONG, 32'h600);
    cmd(CMD_SET_STATUS, 3'h0, SZ_WORD, 32'h2000);
    cmd(CMD_RD_PTR, 3'h7);
    chk(res, 32'h800);
    cmd(CMD_SET_STATUS, 3'h0, SZ_WORD, 32'h0);
    cmd(CMD_PUSH, 3'h7, SZ_BYTE, 32'hA5);
    chk({i_mem.m[12'h5FE], i_mem.m[12'h5FF]}, 32'hA5EE);
    cmd(CMD_RD_PTR, 3'h7);
    chk(res, 32'h5FE);
    cmd(CMD_POP, 3'h7, SZ_BYTE);
    chk(res, 32'hA5);
    cmd(CMD_RD_PTR, 3'h7);
    chk(res, 32'h600);
    $display("system stack test end");
  endtask
  task automatic t_call();
    slow <= 1'b1;
    cmd(CMD_CALL, 3'h0, SZ_LONG, 32'h1234);
    chk(pc, 32'h1234);
    cmd(CMD_CALL, 3'h0, SZ_LONG, 32'h2000);
    chk(peek(12'h5F8), 32'h1234);
    cmd(CMD_RETURN);
    chk(pc, 32'h1234);
    cmd(CMD_RETURN);
    chk(pc, 32'h0);
    $display("call test end");
  endtask
  task automatic t_trap();
    cmd(CMD_TRAP, 3'h0, SZ_LONG, 32'h300);
    chk({trp, sup}, 32'h3);
    chk(pc, 32'h300);
    chk(peek(12'h7FC), 32'h0);
    chk(peek(12'h7F8), 32'hEEEE0000);
    for (int o = 11; o < 16; o++) begin
      cmd(4'(o));
      chk(trp, 1'b1);
      chk(pc, UNIMP_TARGET);
    end
    $display("trap test end");
  endtask
  task automatic t_frame();
    slow <= 1'b0;
    poke(12'h400, 32'h36, 2);
    for (int i = 1; i < 7; i++) poke(12'h400 + 12'(2 * i), 32'hA000 + 32'(i), 2);
    poke(12'h40E, 32'h0, 2);
    poke(12'h410, 32'h3, 2);
    wq.delete();
    cmd(CMD_FRAME);
    @(posedge clk);
    chk(res, 32'h7);
    chk(pc, 32'h40E);
    for (int i = 0; i < 7; i++) begin
      chk(wq[i], {i == 0 ? 2'h0 : i < 3 ? 2'h1 : i < 4 ? 2'h2 : 2'h3,
                  i == 0 ? 16'h0036 : 16'hA000 + 16'(i)});
    end
    cmd(CMD_FRAME);
    chk(res, 32'h1);
    // special count three, class F and an over-long total must all trap
    for (int k = 0; k < 3; k++) begin
      if (k > 0) poke(12'h400, k == 1 ? 32'hF000 : 32'h3E, 2);
      cmd(CMD_FRAME);
      chk(trp, 1'b1);
      chk(pc, UNIMP_TARGET);
    end
    $display("framing test end");
  endtask
  task automatic t_table();
    logic [31:0] e;
    poke(12'h201, 32'h10, 1);
    poke(12'h202, 32'h13, 1);
    poke(12'h222, 32'h10, 2);
    poke(12'h224, 32'h13, 2);
    poke(12'h244, 32'h10, 4);
    poke(12'h248, 32'h13, 4);
    for (int s = 0; s < 3; s++) begin
      cmd(CMD_WR_PTR, 3'h2, SZ_LONG, 32'h200 + 32'(s) * 32'h20);
      for (int r = 0; r < 2; r++) begin
        e = (r == 1 || s == 2) ? 32'h12 : 32'h11;
        cmd(CMD_TABLE, 3'h2, 2'(s), 32'h180, 1'(r));
        chk(res, e);
        chk(frac, e == 32'h11 ? 32'h80 : 32'h0);
      end
    end
    $display("table test end");
  endtask
  task automatic t_halt();
    int n;
    fork
      cmd(CMD_HALT, 3'h0, SZ_WORD, 32'h2300);
      begin
        repeat (10) @(posedge clk);
        irq <= 3'h2;
        repeat (20) @(negedge clk);
        chk(hlt, 1'b1);
        @(posedge clk);
        irq <= 3'h3;
      end
    join
    chk(pc, UNIMP_TARGET);
    @(posedge clk);
    irq <= 3'h5;
    n = 0;
    do @(negedge clk); while (trp !== 1'b1 && ++n < 60);
    chk(pc, 32'h514);
    chk(sw[10:8], 32'h5);
    chk(hlt, 1'b0);
    @(posedge clk);
    irq <= 3'h0;
    $display("halt test end");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk(sw, 32'h2700);
    t_ptrs();
    t_sys();
    t_call();
    t_trap();
    t_frame();
    t_table();
    t_halt();
    print_verdict();
  end
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
endmodule
